// ==== rtl/gpio_pkg.sv ====
/*
  Constants for the two-pin parallel port: register offsets, widths,
  reset values. Assumes an APB slave with 32-bit data, one word a register.
*/
package gpio_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int unsigned PIN_CNT  = 2;
  localparam int unsigned REG_W    = 8;
  localparam int unsigned ADDR_W   = 12;
  localparam int unsigned DATA_W   = 32;

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [ADDR_W-1:0] OFS_DATA   = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_DIR    = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_PULLUP = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_SLEW   = 12'h00C;
  localparam logic [ADDR_W-1:0] OFS_DRIVE  = 12'h010;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [PIN_CNT-1:0] RST_DATA   = 2'h0;
  localparam logic [PIN_CNT-1:0] RST_DIR    = 2'h0;
  localparam logic [PIN_CNT-1:0] RST_PULLUP = 2'h0;
  localparam logic [PIN_CNT-1:0] RST_SLEW   = 2'h0;
  localparam logic [PIN_CNT-1:0] RST_DRIVE  = 2'h0;

endpackage : gpio_pkg

// ==== rtl/parallel_port.sv ====
/*
  Two-pin parallel port with per-pin data latch, direction, pullup,
  slew limiting and drive strength, reached over APB.
  Assumes pin inputs synchronous to core_clk; pad cells outside resolve
  the pin wire from pin_out/pin_oe and apply pullup/slew/drive controls.
*/
// What this block does
// RULE_01: input pins read back their sampled pin level on data reads.
// RULE_02: output pins read back the last written data bit, not pin.
// RULE_03: every data write updates all latch bits regardless of direction; a data write with pstrb[0] low changes nothing.
// RULE_04: output pins are driven with the latched data bit.
// RULE_05: reset clears latches and makes pins undriven inputs, pullup off.
// RULE_06: direction bit zero disables driver; reads return pin value.
// RULE_07: direction bit one enables driver; reads return latched bit.
// RULE_08: pullup bit one turns on that pin's pullup; zero leaves off.
// RULE_09: pullup always off while a pin is an output.
// RULE_10: slew bit one limits output transition rate; zero leaves off.
// RULE_11: slew bits have no effect on input pins.
// RULE_12: drive bit zero selects low drive, one selects high drive.
// RULE_13: software writes zeros to reserved bits seven down to two.
// RULE_14: under peripheral override, direction bit still picks read source.
// RULE_15: analog-enabled pins read zero and lose all digital functions.
// RULE_16: reserved bits seven to two read zero and ignore writes.
`timescale 1ns/1ns
module parallel_port (
  // clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          nrst,
  // apb slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [gpio_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [gpio_pkg::DATA_W-1:0]   pwdata,
  input  wire logic [3:0]                    pstrb,
  output logic      [gpio_pkg::DATA_W-1:0]   prdata,
  output logic                               pready,
  output logic                               pslverr,
  // pins
  input  wire logic [gpio_pkg::PIN_CNT-1:0]  pin_in,
  output logic      [gpio_pkg::PIN_CNT-1:0]  pin_out,
  output logic      [gpio_pkg::PIN_CNT-1:0]  pin_oe,
  // pad controls
  output logic      [gpio_pkg::PIN_CNT-1:0]  pin_pullup_on,
  output logic      [gpio_pkg::PIN_CNT-1:0]  pin_slew_on,
  output logic      [gpio_pkg::PIN_CNT-1:0]  pin_drive_high,
  // shared functions from other units
  input  wire logic [gpio_pkg::PIN_CNT-1:0]  periph_own,
  input  wire logic [gpio_pkg::PIN_CNT-1:0]  periph_oe,
  input  wire logic [gpio_pkg::PIN_CNT-1:0]  periph_out,
  input  wire logic [gpio_pkg::PIN_CNT-1:0]  analog_en
);
  import gpio_pkg::*;

  // ****************************************
  // timing notes
  // ****************************************
  // a transfer takes setup plus two access cycles: the first access
  // cycle samples the read source into prdata_r, the second raises
  // pready; a write lands at that second edge.
  // prdata holds zero outside the ack cycle.
  // pin_in is read as it stands; any synchroniser sits outside.
  // pin_out, pin_oe and pad controls are plain decodes of the
  // register flops plus the shared-function inputs, so a peripheral
  // taking a pin acts in the same cycle.
  // trade-off: one wait state buys a registered read path.
  // pullup and slew decode from the final driver enable, so an
  // output set by a peripheral also turns the pullup off.

  // ****************************************
  // types
  // ****************************************
  // one-hot bus phase; the wait state lets read data leave a flop
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } bus_state_t;

  // ****************************************
  // functions
  // ****************************************
  // per-pin pick: sel high takes a, sel low takes b
  function automatic logic [PIN_CNT-1:0] pick(
    input logic [PIN_CNT-1:0] sel,
    input logic [PIN_CNT-1:0] a,
    input logic [PIN_CNT-1:0] b
  );
    pick = (sel & a) | (~sel & b);
  endfunction : pick

  // RULE_16 reserved bits read zero
  function automatic logic [DATA_W-1:0] widen(
    input logic [PIN_CNT-1:0] v
  );
    widen = {{(DATA_W-PIN_CNT){1'b0}}, v};
  endfunction : widen

  // RULE_16 written reserved bits are dropped
  function automatic logic [PIN_CNT-1:0] low_bits(
    input logic [DATA_W-1:0] w
  );
    low_bits = w[PIN_CNT-1:0];
  endfunction : low_bits

  // ****************************************
  // registers
  // ****************************************
  bus_state_t         bus_state_r;
  bus_state_t         bus_state_nxt;
  logic [PIN_CNT-1:0] port_a_data_latch_r;
  logic [PIN_CNT-1:0] port_a_data_latch_nxt;
  logic [PIN_CNT-1:0] port_a_direction_r;
  logic [PIN_CNT-1:0] port_a_direction_nxt;
  logic [PIN_CNT-1:0] port_a_pullup_enable_r;
  logic [PIN_CNT-1:0] port_a_pullup_enable_nxt;
  logic [PIN_CNT-1:0] port_a_slew_enable_r;
  logic [PIN_CNT-1:0] port_a_slew_enable_nxt;
  logic [PIN_CNT-1:0] port_a_drive_strength_r;
  logic [PIN_CNT-1:0] port_a_drive_strength_nxt;
  logic [DATA_W-1:0]  prdata_r;
  logic [DATA_W-1:0]  prdata_nxt;
  logic [DATA_W-1:0]  read_word;

  // ****************************************
  // bus decode
  // ****************************************
  // request qualifiers
  wire logic access_en;
  wire logic in_ack;
  wire logic capture_rd;
  // address hits
  wire logic hit_data;
  wire logic hit_dir;
  wire logic hit_pullup;
  wire logic hit_slew;
  wire logic hit_drive;
  wire logic hit_any;
  // write strobes
  wire logic lane0;
  wire logic wr_en;
  wire logic wr_data;
  wire logic wr_dir;
  wire logic wr_pullup;
  wire logic wr_slew;
  wire logic wr_drive;

  assign access_en  = psel & penable;
  assign in_ack     = (bus_state_r == BUS_ACK);

  // address compare on the full word; no aliasing of registers
  assign hit_data   = (paddr == OFS_DATA);
  assign hit_dir    = (paddr == OFS_DIR);
  assign hit_pullup = (paddr == OFS_PULLUP);
  assign hit_slew   = (paddr == OFS_SLEW);
  assign hit_drive  = (paddr == OFS_DRIVE);
  assign hit_any    = hit_data | hit_dir | hit_pullup | hit_slew | hit_drive;

  // only lane 0 holds implemented bits
  assign lane0      = pstrb[0];

  // one wait state: pready in the second access cycle only
  assign pready     = access_en & in_ack;
  // unmapped addresses answer with an error and change nothing
  assign pslverr    = pready & ~hit_any;

  // read source sampled in the first access cycle
  assign capture_rd = access_en & ~pwrite & ~in_ack;

  // writes land only at the edge where pready is seen high
  assign wr_en      = pready & pwrite & hit_any & lane0;
  assign wr_data    = wr_en & hit_data;
  assign wr_dir     = wr_en & hit_dir;
  assign wr_pullup  = wr_en & hit_pullup;
  assign wr_slew    = wr_en & hit_slew;
  assign wr_drive   = wr_en & hit_drive;

  // ****************************************
  // bus phase
  // ****************************************
  always_comb begin
    bus_state_nxt = bus_state_r;
    unique case (bus_state_r)
      BUS_IDLE: begin
        if (access_en) begin
          bus_state_nxt = BUS_ACK;
        end
      end
      BUS_ACK: begin
        bus_state_nxt = BUS_IDLE;
      end
      // a corrupted code falls back to idle
      default: begin
        bus_state_nxt = BUS_IDLE;
      end
    endcase
  end

  // bus phase flop
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      bus_state_r <= BUS_IDLE;
    end else begin
      bus_state_r <= bus_state_nxt;
    end
  end

  // ****************************************
  // pin read path
  // ****************************************
  wire logic [PIN_CNT-1:0] data_view;
  wire logic [PIN_CNT-1:0] drv_en;
  wire logic [PIN_CNT-1:0] drv_level;

  // RULE_01 RULE_02 RULE_06 RULE_07 pick source
  // RULE_14 own direction bit decides, even under override
  // RULE_15 analog pins read zero
  assign data_view = pick(port_a_direction_r, port_a_data_latch_r, pin_in)
                     & ~analog_en;

  // ****************************************
  // pin drive and pad controls
  // ****************************************
  // RULE_06 RULE_07 driver follows direction unless a peripheral owns it
  // RULE_15 analog cuts the digital driver
  assign drv_en = pick(periph_own, periph_oe, port_a_direction_r)
                  & ~analog_en;

  // RULE_04 latched level onto output pins
  assign drv_level = pick(periph_own, periph_out, port_a_data_latch_r);
  // undriven pins show 0 so no stale level leaks to the pad
  assign pin_out = drv_level & drv_en;

  // RULE_05 reset direction zero keeps pins undriven
  assign pin_oe = drv_en;

  // RULE_08 RULE_09 pullup only on non-output digital pins
  assign pin_pullup_on = port_a_pullup_enable_r & ~drv_en & ~analog_en;

  // RULE_10 RULE_11 slew only matters while driving
  assign pin_slew_on = port_a_slew_enable_r & drv_en;

  // RULE_12 drive strength select; gated by analog_en only, it only acts when driving
  assign pin_drive_high = port_a_drive_strength_r & ~analog_en;

  // ****************************************
  // read mux
  // ****************************************
  // reads of unmapped addresses return zero
  always_comb begin
    read_word = '0;
    if (hit_data) begin
      read_word = widen(data_view);
    end else if (hit_dir) begin
      read_word = widen(port_a_direction_r);
    end else if (hit_pullup) begin
      read_word = widen(port_a_pullup_enable_r);
    end else if (hit_slew) begin
      read_word = widen(port_a_slew_enable_r);
    end else if (hit_drive) begin
      read_word = widen(port_a_drive_strength_r);
    end
  end

  // cleared outside the ack cycle so stale data never shows
  assign prdata_nxt = capture_rd ? read_word : '0;
  assign prdata     = prdata_r;

  // read data flop
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prdata_r <= '0;
    end else begin
      prdata_r <= prdata_nxt;
    end
  end

  // ****************************************
  // register next values
  // ****************************************
  // RULE_03 every data write with pstrb[0] high updates all latch bits
  assign port_a_data_latch_nxt     = wr_data ? low_bits(pwdata)
                                     : port_a_data_latch_r;
  assign port_a_direction_nxt      = wr_dir ? low_bits(pwdata)
                                     : port_a_direction_r;
  assign port_a_pullup_enable_nxt  = wr_pullup ? low_bits(pwdata)
                                     : port_a_pullup_enable_r;
  assign port_a_slew_enable_nxt    = wr_slew ? low_bits(pwdata)
                                     : port_a_slew_enable_r;
  assign port_a_drive_strength_nxt = wr_drive ? low_bits(pwdata)
                                     : port_a_drive_strength_r;

  // ****************************************
  // register flops
  // ****************************************
  // RULE_03 data latch
  // RULE_05 latches and controls cleared
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      port_a_data_latch_r <= RST_DATA;
    end else begin
      port_a_data_latch_r <= port_a_data_latch_nxt;
    end
  end

  // RULE_07 direction register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      port_a_direction_r <= RST_DIR;
    end else begin
      port_a_direction_r <= port_a_direction_nxt;
    end
  end

  // RULE_08 pullup register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      port_a_pullup_enable_r <= RST_PULLUP;
    end else begin
      port_a_pullup_enable_r <= port_a_pullup_enable_nxt;
    end
  end

  // RULE_10 slew register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      port_a_slew_enable_r <= RST_SLEW;
    end else begin
      port_a_slew_enable_r <= port_a_slew_enable_nxt;
    end
  end

  // RULE_12 drive register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      port_a_drive_strength_r <= RST_DRIVE;
    end else begin
      port_a_drive_strength_r <= port_a_drive_strength_nxt;
    end
  end

endmodule : parallel_port

// ==== testbench/port_chk_sva.sv ====
/* checker for the parallel port top ports.
   assumes one clock, bound from the bench top file */
`timescale 1ns/1ns
module port_chk (
  // clock, reset
  input wire logic                         core_clk,
  input wire logic                         nrst,
  // apb
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pwrite,
  input wire logic [gpio_pkg::ADDR_W-1:0]  paddr,
  input wire logic [gpio_pkg::DATA_W-1:0]  prdata,
  input wire logic                         pready,
  // pins
  input wire logic [gpio_pkg::PIN_CNT-1:0] pin_in,
  input wire logic [gpio_pkg::PIN_CNT-1:0] pin_out,
  input wire logic [gpio_pkg::PIN_CNT-1:0] pin_oe,
  input wire logic [gpio_pkg::PIN_CNT-1:0] pin_pullup_on,
  input wire logic [gpio_pkg::PIN_CNT-1:0] pin_slew_on,
  input wire logic [gpio_pkg::PIN_CNT-1:0] pin_drive_high,
  input wire logic [gpio_pkg::PIN_CNT-1:0] periph_own,
  input wire logic [gpio_pkg::PIN_CNT-1:0] analog_en
);
  import gpio_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // pins under plain port control
  wire [1:0] gp = ~periph_own & ~analog_en;
  wire       rd = psel && penable && !pwrite && pready;
  wire       rdd = rd && paddr == OFS_DATA;
  wire       wr = psel && penable && pwrite;
  chk_rd_pin: assert property
    (rdd |-> ((prdata[1:0] ^ pin_in) & ~pin_oe & gp) == 2'h0)
    else $error("input pin read wrong");
  chk_rd_latch: assert property
    (rdd |-> ((prdata[1:0] ^ pin_out) & pin_oe & gp) == 2'h0)
    else $error("output pin read wrong");
  chk_pull_off: assert property ((pin_pullup_on & pin_oe) == 2'h0)
    else $error("pullup on while driving");
  chk_slew_in: assert property ((pin_slew_on & ~pin_oe) == 2'h0)
    else $error("slew on input pin");
  chk_analog_off: assert property
    ((analog_en & (pin_oe | pin_pullup_on | pin_drive_high)) == 2'h0)
    else $error("analog pin keeps digital use");
  chk_rd_analog: assert property (rdd |-> (prdata[1:0] & analog_en) == 2'h0)
    else $error("analog pin read not zero");
  chk_rsv_zero: assert property (rd |-> prdata[31:2] == 30'h0)
    else $error("reserved bits not zero");
  chk_reset_idle: assert property
    ($rose(nrst) |-> pin_oe == 2'h0 && pin_pullup_on == 2'h0)
    else $error("pins not idle after reset");
  chk_out_hold: assert property
    (!wr && periph_own == 2'h0 |=> $stable(pin_out) || periph_own != 2'h0
      || $changed(analog_en))
    else $error("pin level moved without write");
endmodule : port_chk

// ==== testbench/tb_parallel_port.sv ====
/* directed bench for the parallel port over apb.
   assumes pins are driven straight from the bench */
`timescale 1ns/1ns
module tb_parallel_port;
  import gpio_pkg::*;
  logic core_clk, nrst, psel, penable, pwrite, pready, pslverr, err;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [1:0] pin_in, pin_out, pin_oe, pin_pullup_on, pin_slew_on;
  logic [1:0] pin_drive_high, periph_own, periph_oe, periph_out, analog_en;
  int fails, comparisons;
  parallel_port i_parallel_port (.core_clk, .nrst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .pin_in,
    .pin_out, .pin_oe, .pin_pullup_on, .pin_slew_on, .pin_drive_high,
    .periph_own, .periph_oe, .periph_out, .analog_en);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic check(input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check
  task automatic results;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results
  initial begin
    repeat (3000) @(posedge core_clk);
    fails++;
    results();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pin_in, periph_oe} = '0;
    {periph_own, periph_out, analog_en, nrst} = '0;
    pstrb = 4'hF;
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      xfer(1'b0, OFS_DATA + ADDR_W'(4 * i), '0);
      check(rd, '0);
    end
    check(32'(pin_oe), 32'h0);
    check(32'(pin_pullup_on), 32'h0);
    $display("reset values done");
    xfer(1'b1, OFS_DATA, 32'h3);
    pin_in <= 2'h2;
    xfer(1'b0, OFS_DATA, '0);
    check(rd, 32'h2);
    pin_in <= 2'h0;
    xfer(1'b1, OFS_DIR, 32'h1);
    xfer(1'b0, OFS_DIR, '0);
    check(rd, 32'h1);
    xfer(1'b0, OFS_DATA, '0);
    check(rd, 32'h1);
    @(negedge core_clk);
    check(32'(pin_oe), 32'h1);
    check(32'(pin_out), 32'h1);
    $display("data and direction done");
    xfer(1'b1, OFS_PULLUP, 32'h3);
    xfer(1'b1, OFS_SLEW, 32'h3);
    xfer(1'b1, OFS_DRIVE, 32'h2);
    xfer(1'b1, OFS_DATA, '0);
    @(negedge core_clk);
    check(32'(pin_pullup_on), 32'h2);
    check(32'(pin_slew_on), 32'h1);
    check(32'(pin_drive_high), 32'h2);
    check(32'(pin_out), 32'h0);
    $display("pad controls done");
    @(posedge core_clk);
    periph_own <= 2'h1;
    pin_in <= 2'h1;
    xfer(1'b0, OFS_DATA, '0);
    check(rd, 32'h0);
    analog_en <= 2'h2;
    pin_in <= 2'h3;
    xfer(1'b0, OFS_DATA, '0);
    check(rd, 32'h0);
    @(negedge core_clk);
    check(32'(pin_pullup_on), 32'h1);
    xfer(1'b1, 12'h014, 32'h3);
    check(32'(err), 32'h1);
    $display("shared and unmapped done");
    results();
  end
endmodule : tb_parallel_port
bind parallel_port port_chk i_port_chk (.core_clk, .nrst, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pin_in, .pin_out, .pin_oe,
  .pin_pullup_on,
  .pin_slew_on, .pin_drive_high, .periph_own, .analog_en);
